// >>> sim/cpps_core_model.sv
/*
  Model of the core side of the register bank: pointer and push pulses,
  plus the extension bytes that the core holds itself.
  Assumes the bank samples the pulses on the rising edge of clk and uses the extension bytes unregistered.
*/
`timescale 1ns/1ps
module cpps_core_model (
  // clock
  input wire logic clk,
  // instruction pulses
  output cpps_pkg::cpps_op_type ptr_op,
  output logic [15:0] ptr_load_value,
  output logic push_req,
  // extension bytes held in the core
  output logic [1:0] stack_extension_byte,
  output logic stack_extension_enable,
  output logic [7:0] pointer_zero_extension_byte,
  output logic [7:0] pointer_one_extension_byte
);
  initial begin
    ptr_op = cpps_pkg::CPPS_OP_NONE;
    ptr_load_value = 16'h0000;
    push_req = 1'b0;
    stack_extension_byte = 2'b00;
    stack_extension_enable = 1'b0;
    pointer_zero_extension_byte = 8'h00;
    pointer_one_extension_byte = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic op(input cpps_pkg::cpps_op_type o, input logic [15:0] v);
    @(posedge clk);
    ptr_op <= o;
    ptr_load_value <= v;
    @(posedge clk);
    ptr_op <= cpps_pkg::CPPS_OP_NONE;
    // stale load value must not be relied on
    ptr_load_value <= ~v;
  endtask : op
  task automatic push();
    @(posedge clk);
    push_req <= 1'b1;
    @(posedge clk);
    push_req <= 1'b0;
  endtask : push
  task automatic ext(input logic [7:0] z, input logic [7:0] o, input logic [1:0] s,
                     input logic e);
    @(posedge clk);
    pointer_zero_extension_byte <= z;
    pointer_one_extension_byte <= o;
    stack_extension_byte <= s;
    stack_extension_enable <= e;
  endtask : ext
endmodule : cpps_core_model

// >>> sim/testbench.sv
/*
  Self-checking bench for the core register bank.
  Assumes one 100 MHz clock and the core model on the instruction side.
*/
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  cpps_pkg::cpps_op_type ptr_op;
  logic [15:0] ptr_load_value;
  logic push_req;
  logic [1:0] stack_extension_byte;
  logic stack_extension_enable;
  logic [7:0] pointer_zero_extension_byte;
  logic [7:0] pointer_one_extension_byte;
  logic [23:0] active_pointer;
  logic [9:0] stack_address;
  logic [7:0] port_four_function_control = 8'h00;
  logic [7:0] port_four_mem_sel;
  logic [7:0] port_four_pin_value;
  logic osc_slow_pin = 1'b0;
  logic reset_by_osc_fail = 1'b0;
  logic osc_fail_reset_req;
  logic irq;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  cpps_core_model core (.clk, .ptr_op, .ptr_load_value, .push_req, .stack_extension_byte,
    .stack_extension_enable, .pointer_zero_extension_byte, .pointer_one_extension_byte);
  cpps_bank uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ptr_op, .ptr_load_value, .push_req, .stack_extension_byte, .stack_extension_enable,
    .pointer_zero_extension_byte, .pointer_one_extension_byte, .active_pointer,
    .stack_address, .port_four_function_control, .port_four_mem_sel, .port_four_pin_value,
    .osc_slow_pin, .reset_by_osc_fail, .osc_fail_reset_req, .irq);
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // read data stands one cycle only, so sample just after its edge
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rc
  ////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    logic [7:0] e [8];
    e = '{cpps_pkg::RST_PORT_FOUR_LATCH, cpps_pkg::RST_STACK_TOP_POINTER,
      8'h00, 8'h00, 8'h00, 8'h00, cpps_pkg::RST_POINTER_CHOICE, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rc(8'h80 + 8'(i), e[i]);
    end
    rc(8'hF8, 8'h00);
    rc(8'hF9, 8'h00);
    wr(8'h90, 8'h5A);
    rc(8'h90, 8'h00);
  endtask : s_reset
  task automatic s_port();
    wr(8'h80, 8'h0F);
    @(posedge clk) port_four_function_control <= 8'h3C;
    #1 chk(port_four_mem_sel, 8'h0C);
    chk(port_four_pin_value, 8'h0F);
    rc(8'h80, 8'h3F);
  endtask : s_port
  task automatic s_ptr();
    core.ext(8'hAA, 8'hBB, 2'b10, 1'b0);
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    wr(8'h84, 8'h78);
    wr(8'h85, 8'h56);
    #1 chk(active_pointer, 24'hAA1234);
    rc(8'h83, 8'h12);
    wr(8'h86, 8'h01);
    #1 chk(active_pointer, 24'hBB5678);
    wr(8'h86, 8'hFF);
    rc(8'h86, 8'hE5);
  endtask : s_ptr
  task automatic s_dir();
    wr(8'h86, 8'h40);
    core.op(cpps_pkg::CPPS_OP_INC, 16'h0000);
    #1 chk(active_pointer, 24'hAA1233);
    wr(8'h86, 8'hC1);
    core.op(cpps_pkg::CPPS_OP_INC, 16'h0000);
    #1 chk(active_pointer, 24'hBB5677);
    wr(8'h86, 8'h01);
    core.op(cpps_pkg::CPPS_OP_INC, 16'h0000);
    #1 chk(active_pointer, 24'hBB5678);
    wr(8'h86, 8'h00);
    core.op(cpps_pkg::CPPS_OP_LOAD, 16'hBEEF);
    #1 chk(active_pointer, 24'hAABEEF);
  endtask : s_dir
  task automatic s_toggle();
    logic s;
    s = 1'b0;
    wr(8'h86, 8'h20);
    for (int i = 1; i < 6; i++) begin
      core.op(cpps_pkg::cpps_op_type'(i), 16'h0100);
      s = ~s;
      rc(8'h86, {7'h12, s});
    end
    wr(8'h86, 8'h00);
    core.op(cpps_pkg::CPPS_OP_CODE_READ, 16'h0000);
    rc(8'h86, 8'h04);
  endtask : s_toggle
  task automatic s_stack();
    wr(8'h81, 8'h20);
    #1 chk(stack_address, 10'h021);
    core.push();
    rc(8'h81, 8'h21);
    core.ext(8'hAA, 8'hBB, 2'b10, 1'b1);
    #1 chk(stack_address, 10'h222);
    wr(8'h81, 8'hFF);
    #1 chk(stack_address, 10'h300);
    core.push();
    rc(8'h81, 8'h00);
    rc(8'hF8, 8'h02);
    chk(irq, 1'b0);
    wr(8'hF9, 8'h02);
    #1 chk(irq, 1'b1);
    wr(8'hF8, 8'h02);
    #1 chk(irq, 1'b0);
    rc(8'hF8, 8'h00);
  endtask : s_stack
  task automatic s_osc();
    @(posedge clk) osc_slow_pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(osc_fail_reset_req, 1'b0);
    wr(8'h87, 8'h13);
    #1 chk(osc_fail_reset_req, 1'b1);
    rc(8'h87, 8'h10);
    @(posedge clk) osc_slow_pin <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(osc_fail_reset_req, 1'b0);
  endtask : s_osc
  task automatic s_flag();
    @(posedge clk);
    rst_n <= 1'b0;
    reset_by_osc_fail <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reset_by_osc_fail <= 1'b0;
    repeat (2) @(posedge clk);
    // enable falls with any reset, the flag is loaded from reset_by_osc_fail
    rc(8'h87, 8'h20);
    rc(8'hF8, 8'h01);
    wr(8'hF9, 8'h01);
    #1 chk(irq, 1'b1);
    wr(8'h87, 8'h20);
    rc(8'h87, 8'h20);
    wr(8'h87, 8'h00);
    rc(8'h87, 8'h00);
  endtask : s_flag
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    s_reset();
    s_port();
    s_ptr();
    s_dir();
    s_toggle();
    s_stack();
    s_osc();
    s_flag();
    wrap_up();
  end
endmodule : testbench

// >>> src/cpps_bank.sv
/*
  Core register bank: port four latch, stack pointer, two data pointers,
  pointer choice and power control, plus a small interrupt block.
  Assumes the core drives one-cycle strobes and instruction pulses on clk.
*/
// Strobed register access was decided locally.
// Behaviour
// - pin memory function needs latch and control
// - stack pointer increments before each push
// - extended stack joins extension byte above pointer
// - pointer zero is 16-bit at 82h/83h
// - choice bit selects pointer one bytes
// - direction bit picks increment or decrement
// - osc fail flag sticky until software clears; any reset reloads it from reset_by_osc_fail
// - osc fail reset only while enabled
`timescale 1ns/1ps
module cpps_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core instruction side
  input wire cpps_pkg::cpps_op_type ptr_op,
  input wire logic [15:0] ptr_load_value,
  input wire logic push_req,
  input wire logic [1:0] stack_extension_byte,
  input wire logic stack_extension_enable,
  input wire logic [7:0] pointer_zero_extension_byte,
  input wire logic [7:0] pointer_one_extension_byte,
  output logic [23:0] active_pointer,
  output logic [9:0] stack_address,
  // port four pins
  input wire logic [7:0] port_four_function_control,
  output logic [7:0] port_four_mem_sel,
  output logic [7:0] port_four_pin_value,
  // oscillator monitor, async pin
  input wire logic osc_slow_pin,
  input wire logic reset_by_osc_fail,
  output logic osc_fail_reset_req,
  // interrupt
  output logic irq
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] port_four_latch;
    logic [7:0] stack_top_pointer;
    logic [7:0] pointer_zero_low_byte;
    logic [7:0] pointer_zero_high_byte;
    logic [7:0] pointer_one_low_byte;
    logic [7:0] pointer_one_high_byte;
    logic [7:0] pointer_choice_control;
    logic [7:0] power_control;
    logic [cpps_pkg::IRQ_W-1:0] irq_status;
    logic [cpps_pkg::IRQ_W-1:0] irq_mask;
    logic [7:0] rdata;
    logic [1:0] osc_sync;
    logic reset_seen;
  } cpps_state_type;

  cpps_state_type s_q;
  cpps_state_type s_d;

  logic sel;
  logic [23:0] ptr_zero;
  logic [23:0] ptr_one;
  logic [23:0] stepped;
  logic step_dec;
  logic [7:0] sp_inc;
  logic [9:0] push_addr;
  logic stack_wrap;
  logic osc_slow;

  function automatic logic is_ptr_op(input cpps_pkg::cpps_op_type op);
    is_ptr_op = (op != cpps_pkg::CPPS_OP_NONE);
  endfunction : is_ptr_op

  //////////////////////////////////////////////////////////////////////////////
  assign sel = s_q.pointer_choice_control[cpps_pkg::POS_POINTER_SELECT];
  assign ptr_zero = {pointer_zero_extension_byte, s_q.pointer_zero_high_byte,
                     s_q.pointer_zero_low_byte};
  assign ptr_one = {pointer_one_extension_byte, s_q.pointer_one_high_byte,
                    s_q.pointer_one_low_byte};
  assign active_pointer = sel ? ptr_one : ptr_zero;
  assign step_dec = sel ? s_q.pointer_choice_control[cpps_pkg::POS_POINTER_ONE_DIR]
                        : s_q.pointer_choice_control[cpps_pkg::POS_POINTER_ZERO_DIR];
  // second synchroniser stage only
  assign osc_slow = s_q.osc_sync[1];

  cpps_ptr_step u_step (
    .ptr_in(active_pointer),
    .dec(step_dec),
    .ptr_out(stepped)
  );

  cpps_stack_addr u_stack (
    .sp(s_q.stack_top_pointer),
    .ext(stack_extension_byte),
    .ext_en(stack_extension_enable),
    .sp_inc(sp_inc),
    .push_addr(push_addr),
    .wrap(stack_wrap)
  );

  assign stack_address = push_addr;
  assign port_four_mem_sel = s_q.port_four_latch & port_four_function_control;
  assign port_four_pin_value = s_q.port_four_latch;
  // request is a level; the system reset logic acts on it
  assign osc_fail_reset_req = osc_slow
      & s_q.power_control[cpps_pkg::POS_OSC_FAIL_ENABLE];
  assign irq = |(s_q.irq_status & s_q.irq_mask);
  assign reg_rdata = s_q.rdata;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.osc_sync = {s_q.osc_sync[0], osc_slow_pin};
    s_d.rdata = 8'h00;
    // software writes first; core operations below take precedence
    if (reg_wr) begin
      unique case (reg_addr)
        cpps_pkg::OFS_PORT_FOUR_LATCH: s_d.port_four_latch = reg_wdata;
        cpps_pkg::OFS_STACK_TOP_POINTER: s_d.stack_top_pointer = reg_wdata;
        cpps_pkg::OFS_POINTER_ZERO_LOW: s_d.pointer_zero_low_byte = reg_wdata;
        cpps_pkg::OFS_POINTER_ZERO_HIGH: s_d.pointer_zero_high_byte = reg_wdata;
        cpps_pkg::OFS_POINTER_ONE_LOW: s_d.pointer_one_low_byte = reg_wdata;
        cpps_pkg::OFS_POINTER_ONE_HIGH: s_d.pointer_one_high_byte = reg_wdata;
        cpps_pkg::OFS_POINTER_CHOICE: begin
          // bits 4..1 are fixed at 0010
          s_d.pointer_choice_control = (reg_wdata & ~cpps_pkg::CHOICE_FIXED_MASK)
              | (cpps_pkg::RST_POINTER_CHOICE & cpps_pkg::CHOICE_FIXED_MASK);
        end
        cpps_pkg::OFS_POWER_CONTROL: begin
          // flag can only be cleared by software, never set
          s_d.power_control = reg_wdata;
          s_d.power_control[cpps_pkg::POS_OSC_FAIL_FLAG] =
              s_q.power_control[cpps_pkg::POS_OSC_FAIL_FLAG]
              & reg_wdata[cpps_pkg::POS_OSC_FAIL_FLAG];
        end
        cpps_pkg::OFS_IRQ_STATUS: begin
          s_d.irq_status = s_q.irq_status & ~reg_wdata[cpps_pkg::IRQ_W-1:0];
        end
        cpps_pkg::OFS_IRQ_MASK: s_d.irq_mask = reg_wdata[cpps_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        cpps_pkg::OFS_PORT_FOUR_LATCH: begin
          // pins in memory use read back as one
          s_d.rdata = s_q.port_four_latch | port_four_function_control;
        end
        cpps_pkg::OFS_STACK_TOP_POINTER: s_d.rdata = s_q.stack_top_pointer;
        cpps_pkg::OFS_POINTER_ZERO_LOW: s_d.rdata = s_q.pointer_zero_low_byte;
        cpps_pkg::OFS_POINTER_ZERO_HIGH: s_d.rdata = s_q.pointer_zero_high_byte;
        cpps_pkg::OFS_POINTER_ONE_LOW: s_d.rdata = s_q.pointer_one_low_byte;
        cpps_pkg::OFS_POINTER_ONE_HIGH: s_d.rdata = s_q.pointer_one_high_byte;
        cpps_pkg::OFS_POINTER_CHOICE: s_d.rdata = s_q.pointer_choice_control;
        cpps_pkg::OFS_POWER_CONTROL: begin
          // stop and idle always read as zero
          s_d.rdata = s_q.power_control;
          s_d.rdata[cpps_pkg::POS_STOP] = 1'b0;
          s_d.rdata[cpps_pkg::POS_IDLE] = 1'b0;
        end
        cpps_pkg::OFS_IRQ_STATUS: s_d.rdata = {6'h00, s_q.irq_status};
        cpps_pkg::OFS_IRQ_MASK: s_d.rdata = {6'h00, s_q.irq_mask};
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (push_req) begin
      s_d.stack_top_pointer = sp_inc;
      if (stack_wrap) begin
        s_d.irq_status[cpps_pkg::IRQ_STACK_WRAP] = 1'b1;
      end
    end
    unique case (ptr_op)
      cpps_pkg::CPPS_OP_INC: begin
        if (sel) begin
          {s_d.pointer_one_high_byte, s_d.pointer_one_low_byte} = stepped[15:0];
        end else begin
          {s_d.pointer_zero_high_byte, s_d.pointer_zero_low_byte} = stepped[15:0];
        end
      end
      cpps_pkg::CPPS_OP_LOAD: begin
        if (sel) begin
          {s_d.pointer_one_high_byte, s_d.pointer_one_low_byte} = ptr_load_value;
        end else begin
          {s_d.pointer_zero_high_byte, s_d.pointer_zero_low_byte} = ptr_load_value;
        end
      end
      default: ;
    endcase
    if (is_ptr_op(ptr_op) && s_q.pointer_choice_control[cpps_pkg::POS_AUTO_TOGGLE]) begin
      s_d.pointer_choice_control[cpps_pkg::POS_POINTER_SELECT] = ~sel;
    end
    // event from the reset logic wins over a software clear
    if (s_q.reset_seen) begin
      s_d.reset_seen = 1'b0;
      s_d.power_control[cpps_pkg::POS_OSC_FAIL_FLAG] = 1'b1;
      s_d.irq_status[cpps_pkg::IRQ_OSC_FAIL] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.port_four_latch <= cpps_pkg::RST_PORT_FOUR_LATCH;
      s_q.stack_top_pointer <= cpps_pkg::RST_STACK_TOP_POINTER;
      s_q.pointer_zero_low_byte <= cpps_pkg::RST_POINTER_BYTE;
      s_q.pointer_zero_high_byte <= cpps_pkg::RST_POINTER_BYTE;
      s_q.pointer_one_low_byte <= cpps_pkg::RST_POINTER_BYTE;
      s_q.pointer_one_high_byte <= cpps_pkg::RST_POINTER_BYTE;
      s_q.pointer_choice_control <= cpps_pkg::RST_POINTER_CHOICE;
      // enable clears on any reset; a kept flag would power up unknown,
      // so the reset logic names the cause of the reset now held
      s_q.power_control <= cpps_pkg::RST_POWER_CONTROL
          | {2'h0, reset_by_osc_fail, 5'h00};
      s_q.irq_status <= '0;
      s_q.irq_mask <= '0;
      s_q.rdata <= 8'h00;
      s_q.osc_sync <= 2'h0;
      // cause is caught by the clock while reset is held
      s_q.reset_seen <= reset_by_osc_fail;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_push_preinc: assert property (@(posedge clk) disable iff (!rst_n)
    push_req |=> s_q.stack_top_pointer == $past(s_q.stack_top_pointer) + 8'h01)
    else $error("push did not pre-increment stack pointer");
  a_ext_stack_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (stack_extension_enable && s_q.stack_top_pointer != 8'hFF) |->
    stack_address == {stack_extension_byte, s_q.stack_top_pointer + 8'h01})
    else $error("extended stack address malformed");
  a_ptr_zero_bytes: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == cpps_pkg::OFS_POINTER_ZERO_HIGH && ptr_op == cpps_pkg::CPPS_OP_NONE)
    |=> s_q.pointer_zero_high_byte == $past(reg_wdata))
    else $error("pointer zero high byte not written");
  a_choice_active: assert property (@(posedge clk) disable iff (!rst_n)
    sel |-> active_pointer[15:0] == {s_q.pointer_one_high_byte, s_q.pointer_one_low_byte})
    else $error("active pointer not pointer one");
  a_inc_direction: assert property (@(posedge clk) disable iff (!rst_n)
    (ptr_op == cpps_pkg::CPPS_OP_INC && !sel && !step_dec && !reg_wr) |=>
    {s_q.pointer_zero_high_byte, s_q.pointer_zero_low_byte} ==
    $past({s_q.pointer_zero_high_byte, s_q.pointer_zero_low_byte}) + 16'h0001)
    else $error("pointer zero did not increment");
  a_osc_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.power_control[cpps_pkg::POS_OSC_FAIL_FLAG] && !reg_wr)
    |=> s_q.power_control[cpps_pkg::POS_OSC_FAIL_FLAG])
    else $error("osc fail flag cleared without software");
  a_osc_reset_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.power_control[cpps_pkg::POS_OSC_FAIL_ENABLE] |-> !osc_fail_reset_req)
    else $error("osc fail reset while disabled");
  a_auto_toggle: assert property (@(posedge clk) disable iff (!rst_n)
    (is_ptr_op(ptr_op) && s_q.pointer_choice_control[cpps_pkg::POS_AUTO_TOGGLE] && !reg_wr)
    |=> sel != $past(sel))
    else $error("choice bit not toggled");
  a_mem_select: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.port_four_latch[3] |-> !port_four_mem_sel[3])
    else $error("pin in memory use with latch clear");

  //////////////////////////////////////////////////////////////////////////////
  // read port, pointer steps, stack address, port four pins, oscillator monitor and interrupts
  a_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd
    |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_read_stack: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == cpps_pkg::OFS_STACK_TOP_POINTER)
    |=> reg_rdata == $past(s_q.stack_top_pointer))
    else $error("stack pointer read back wrong");
  a_read_choice: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == cpps_pkg::OFS_POINTER_CHOICE)
    |=> reg_rdata == $past(s_q.pointer_choice_control))
    else $error("pointer choice read back wrong");
  a_choice_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.pointer_choice_control & cpps_pkg::CHOICE_FIXED_MASK) ==
    (cpps_pkg::RST_POINTER_CHOICE & cpps_pkg::CHOICE_FIXED_MASK))
    else $error("fixed choice bits changed");
  a_load_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (ptr_op == cpps_pkg::CPPS_OP_LOAD && !sel && !reg_wr) |=>
    {s_q.pointer_zero_high_byte, s_q.pointer_zero_low_byte} == $past(ptr_load_value))
    else $error("load missed pointer zero");
  a_zero_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (ptr_op == cpps_pkg::CPPS_OP_INC && sel && !reg_wr) |=>
    {s_q.pointer_zero_high_byte, s_q.pointer_zero_low_byte} ==
    $past({s_q.pointer_zero_high_byte, s_q.pointer_zero_low_byte}))
    else $error("inactive pointer zero stepped");
  a_dec_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (ptr_op == cpps_pkg::CPPS_OP_INC && !sel && step_dec && !reg_wr) |=>
    {s_q.pointer_zero_high_byte, s_q.pointer_zero_low_byte} ==
    $past({s_q.pointer_zero_high_byte, s_q.pointer_zero_low_byte}) - 16'h0001)
    else $error("pointer zero did not decrement");
  a_dec_one: assert property (@(posedge clk) disable iff (!rst_n)
    (ptr_op == cpps_pkg::CPPS_OP_INC && sel && step_dec && !reg_wr) |=>
    {s_q.pointer_one_high_byte, s_q.pointer_one_low_byte} ==
    $past({s_q.pointer_one_high_byte, s_q.pointer_one_low_byte}) - 16'h0001)
    else $error("pointer one did not decrement");
  a_toggle_off: assert property (@(posedge clk) disable iff (!rst_n)
    (is_ptr_op(ptr_op) && !s_q.pointer_choice_control[cpps_pkg::POS_AUTO_TOGGLE]
    && !reg_wr) |=> sel == $past(sel))
    else $error("choice bit moved with toggle off");
  a_stack_wrap_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (stack_extension_enable && s_q.stack_top_pointer == 8'hFF) |->
    stack_address == {stack_extension_byte + 2'h1, 8'h00})
    else $error("extended stack address did not carry");
  a_plain_stack: assert property (@(posedge clk) disable iff (!rst_n)
    !stack_extension_enable |->
    stack_address == {2'h0, s_q.stack_top_pointer + 8'h01})
    else $error("plain stack address malformed");
  a_mem_needs_ctrl: assert property (@(posedge clk) disable iff (!rst_n)
    (port_four_mem_sel & ~port_four_function_control) == 8'h00)
    else $error("pin in memory use without control");
  a_osc_reset_on: assert property (@(posedge clk) disable iff (!rst_n)
    (osc_slow && s_q.power_control[cpps_pkg::POS_OSC_FAIL_ENABLE]) |->
    osc_fail_reset_req)
    else $error("slow crystal without reset request");
  a_osc_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.reset_seen
    |=> s_q.power_control[cpps_pkg::POS_OSC_FAIL_FLAG])
    else $error("osc fail flag not set after its reset");
  a_flag_no_set: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_q.power_control[cpps_pkg::POS_OSC_FAIL_FLAG] && !s_q.reset_seen)
    |=> !s_q.power_control[cpps_pkg::POS_OSC_FAIL_FLAG])
    else $error("osc fail flag set by software");
  a_wrap_status: assert property (@(posedge clk) disable iff (!rst_n)
    (push_req && stack_wrap)
    |=> s_q.irq_status[cpps_pkg::IRQ_STACK_WRAP])
    else $error("stack wrap not flagged");
  a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == cpps_pkg::OFS_IRQ_STATUS && !push_req
    && reg_wdata[cpps_pkg::IRQ_STACK_WRAP]) |=> !s_q.irq_status[cpps_pkg::IRQ_STACK_WRAP])
    else $error("stack wrap status not cleared");
  a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.irq_mask == '0)
    |-> !irq)
    else $error("interrupt raised while all masked");

  c_push: cover property (@(posedge clk) disable iff (!rst_n) push_req ##1 push_req);
  c_toggle: cover property (@(posedge clk) disable iff (!rst_n)
    is_ptr_op(ptr_op) ##1 is_ptr_op(ptr_op));
  c_osc_req: cover property (@(posedge clk) disable iff (!rst_n) osc_fail_reset_req);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  c_load: cover property (@(posedge clk) disable iff (!rst_n) ptr_op == cpps_pkg::CPPS_OP_LOAD);
endmodule : cpps_bank

// >>> src/cpps_pkg.sv
/*
  Constants for the core pointer, port and power register bank.
  Assumes a single 100 MHz clock domain and an 8-bit register port.
*/
package cpps_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_PORT_FOUR_LATCH = 8'h80;
  localparam logic [7:0] OFS_STACK_TOP_POINTER = 8'h81;
  localparam logic [7:0] OFS_POINTER_ZERO_LOW = 8'h82;
  localparam logic [7:0] OFS_POINTER_ZERO_HIGH = 8'h83;
  localparam logic [7:0] OFS_POINTER_ONE_LOW = 8'h84;
  localparam logic [7:0] OFS_POINTER_ONE_HIGH = 8'h85;
  localparam logic [7:0] OFS_POINTER_CHOICE = 8'h86;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h87;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hF8;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hF9;

  // reset values
  localparam logic [7:0] RST_PORT_FOUR_LATCH = 8'hFF;
  localparam logic [7:0] RST_STACK_TOP_POINTER = 8'h07;
  localparam logic [7:0] RST_POINTER_BYTE = 8'h00;
  localparam logic [7:0] RST_POINTER_CHOICE = 8'h04;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;

  // pointer choice control fields
  localparam int unsigned POS_POINTER_SELECT = 0;
  localparam int unsigned POS_AUTO_TOGGLE = 5;
  localparam int unsigned POS_POINTER_ZERO_DIR = 6;
  localparam int unsigned POS_POINTER_ONE_DIR = 7;
  localparam logic [7:0] CHOICE_FIXED_MASK = 8'h1E;

  // power control fields
  localparam int unsigned POS_IDLE = 0;
  localparam int unsigned POS_STOP = 1;
  localparam int unsigned POS_OSC_FAIL_ENABLE = 4;
  localparam int unsigned POS_OSC_FAIL_FLAG = 5;

  // interrupt status bits
  localparam int unsigned IRQ_OSC_FAIL = 0;
  localparam int unsigned IRQ_STACK_WRAP = 1;
  localparam int unsigned IRQ_W = 2;

  // oscillator fail threshold
  localparam int unsigned OSC_FAIL_KHZ = 30;
  localparam int unsigned CLK_MHZ = 100;

  // pointer instructions issued by the core
  typedef enum logic [2:0] {
    CPPS_OP_NONE,
    CPPS_OP_INC,
    CPPS_OP_LOAD,
    CPPS_OP_CODE_READ,
    CPPS_OP_EXT_WRITE,
    CPPS_OP_EXT_READ
  } cpps_op_type;
endpackage : cpps_pkg

// >>> src/cpps_ptr_step.sv
/*
  Steps a 24-bit data pointer up or down by one.
  Assumes purely combinational use by the register bank.
*/
`timescale 1ns/1ps
module cpps_ptr_step (
  // pointer in
  input wire logic [23:0] ptr_in,
  input wire logic dec,
  // pointer out
  output logic [23:0] ptr_out
);
  always_comb begin
    if (dec) begin
      ptr_out = ptr_in - 24'h000001;
    end else begin
      ptr_out = ptr_in + 24'h000001;
    end
  end
endmodule : cpps_ptr_step

// >>> src/cpps_stack_addr.sv
/*
  Forms the stack address and the pre-incremented push pointer.
  Assumes the extension byte comes from outside this bank.
*/
`timescale 1ns/1ps
module cpps_stack_addr (
  // inputs
  input wire logic [7:0] sp,
  input wire logic [1:0] ext,
  input wire logic ext_en,
  // outputs
  output logic [7:0] sp_inc,
  output logic [9:0] push_addr,
  output logic wrap
);
  always_comb begin
    sp_inc = sp + 8'h01;
    wrap = (sp == 8'hFF);
    // extended stack joins the extension bits above the pointer
    if (ext_en) begin
      push_addr = {wrap ? ext + 2'h1 : ext, sp_inc};
    end else begin
      push_addr = {2'h0, sp_inc};
    end
  end
endmodule : cpps_stack_addr
